// [exc_pkg.sv]
// Constants shared by the exception-entry block and its helpers.
// Assumes a 64-bit core; bit n of the big-endian numbering is vector bit 63-n.
package exc_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses on the plain port)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_RET    = 8'h00;
    localparam logic [7:0] OFF_SAVED  = 8'h08;
    localparam logic [7:0] OFF_MS     = 8'h10;
    localparam logic [7:0] OFF_FSTAT  = 8'h18;
    localparam logic [7:0] OFF_FADDR  = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h28;

    // ------------------------------------------------------------
    // Machine state field positions (vector numbering)
    // ------------------------------------------------------------
    localparam int MS_WIDE     = 63;
    localparam int MS_NAP      = 18;
    localparam int MS_IENDIAN  = 16;
    localparam int MS_XIRQ_EN  = 15;
    localparam int MS_USER     = 14;
    localparam int MS_FPU      = 13;
    localparam int MS_MCHK     = 12;
    localparam int MS_FXM_LO   = 11;
    localparam int MS_STEP     = 10;
    localparam int MS_BR_TRACE = 9;
    localparam int MS_FXM_HI   = 8;
    localparam int MS_ITRANS   = 5;
    localparam int MS_DTRANS   = 4;
    localparam int MS_PMARK    = 2;
    localparam int MS_RECOV    = 1;
    localparam int MS_LENDIAN  = 0;

    // Saved-state bits copied from machine state; all others cleared
    localparam logic [63:0] SAVED_COPY_MASK  = 64'h8000_0000_0000_ff73;
    localparam logic [63:0] SAVED_CLEAR_MASK = 64'h0000_0000_783f_0000;

    // ------------------------------------------------------------
    // Reset values, vectors, geometry
    // ------------------------------------------------------------
    localparam logic [63:0] REG_RST      = 64'h0;
    localparam logic [63:0] EXT_VECTOR   = 64'h0000_0000_0000_0500;
    localparam logic [63:0] ALIGN_VECTOR = 64'h0000_0000_0000_0600;
    localparam int          PAGE_BITS    = 12;
    localparam int          CAUSE_W      = 7;

    typedef enum logic [2:0] {
        KIND_INT     = 3'h0,
        KIND_FLOAT   = 3'h1,
        KIND_MULTI   = 3'h2,
        KIND_STRING  = 3'h3,
        KIND_RESERVE = 3'h4,
        KIND_CSTORE  = 3'h5,
        KIND_EXTCTL  = 3'h6,
        KIND_CZERO   = 3'h7
    } mem_kind_t;

endpackage : exc_pkg

// [entry_state_builder.sv]
// Builds saved state and rewritten machine state for exception entry.
// Pure combinational; the caller registers the results.
module entry_state_builder (
    input  wire logic [63:0] ms_i,
    output logic      [63:0] saved_o,
    output logic      [63:0] ms_o
);

    always_comb begin
        saved_o = ms_i & exc_pkg::SAVED_COPY_MASK;
        ms_o                       = ms_i;
        ms_o[exc_pkg::MS_WIDE]     = 1'b1;
        ms_o[exc_pkg::MS_NAP]      = 1'b0;
        ms_o[exc_pkg::MS_XIRQ_EN]  = 1'b0;
        ms_o[exc_pkg::MS_USER]     = 1'b0;
        ms_o[exc_pkg::MS_FPU]      = 1'b0;
        ms_o[exc_pkg::MS_FXM_LO]   = 1'b0;
        ms_o[exc_pkg::MS_STEP]     = 1'b0;
        ms_o[exc_pkg::MS_BR_TRACE] = 1'b0;
        ms_o[exc_pkg::MS_FXM_HI]   = 1'b0;
        ms_o[exc_pkg::MS_ITRANS]   = 1'b0;
        ms_o[exc_pkg::MS_DTRANS]   = 1'b0;
        ms_o[exc_pkg::MS_PMARK]    = 1'b0;
        ms_o[exc_pkg::MS_RECOV]    = 1'b0;
        ms_o[exc_pkg::MS_LENDIAN]  = ms_i[exc_pkg::MS_IENDIAN];
    end

endmodule : entry_state_builder

// [align_checker.sv]
// Classifies one memory access as alignment-faulting or not.
// Assumes the MMU reports segment, block and attribute crossings.
module align_checker #(
    parameter bit CSTORE_FAIL_ALIGN = 1'b1
) (
    input  wire logic [63:0]                 ea_i,
    input  wire logic [7:0]                  size_i,
    input  wire exc_pkg::mem_kind_t          kind_i,
    input  wire logic                        wt_i,
    input  wire logic                        ci_i,
    input  wire logic                        seg_cross_i,
    input  wire logic                        attr_differ_i,
    input  wire logic                        cstore_fail_i,
    input  wire logic                        dtrans_i,
    input  wire logic                        lendian_i,
    output logic                             hit_o,
    output logic [exc_pkg::CAUSE_W-1:0]      cause_o
);

    logic [12:0] last_off;
    logic        page_cross;
    logic        misalign;
    logic        word_mis;
    logic        slow_mem;
    logic        multi;

    always_comb begin
        last_off   = {1'b0, ea_i[exc_pkg::PAGE_BITS-1:0]} + {5'h0, size_i} - 13'h1;
        // Boundaries only exist while data translation is on
        page_cross = dtrans_i && last_off[12];
        misalign   = (ea_i[7:0] & (size_i - 8'h1)) != 8'h0;
        word_mis   = ea_i[1:0] != 2'h0;
        slow_mem   = wt_i || ci_i;
        multi      = kind_i == exc_pkg::KIND_MULTI;
        cause_o    = '0;
        cause_o[0] = kind_i == exc_pkg::KIND_FLOAT && (word_mis || page_cross);
        cause_o[1] = (multi || kind_i == exc_pkg::KIND_EXTCTL) ? word_mis :
                     (kind_i == exc_pkg::KIND_RESERVE
                      || kind_i == exc_pkg::KIND_CSTORE) ? misalign : 1'b0;
        cause_o[2] = kind_i == exc_pkg::KIND_INT && misalign && lendian_i;
        cause_o[3] = (multi || kind_i == exc_pkg::KIND_STRING)
                     && (slow_mem || lendian_i);
        cause_o[4] = multi && dtrans_i && (seg_cross_i || attr_differ_i);
        cause_o[5] = misalign && slow_mem;
        cause_o[6] = slow_mem && (kind_i == exc_pkg::KIND_CZERO
                     || kind_i == exc_pkg::KIND_RESERVE
                     || (kind_i == exc_pkg::KIND_CSTORE
                         && (CSTORE_FAIL_ALIGN || !cstore_fail_i)));
        hit_o      = |cause_o;
    end

endmodule : align_checker

// [exception_entry.sv]
// Exception entry for the external interrupt and alignment exceptions.
// Assumes the core stalls fetch on redirect and reports accesses in order.

// What this block does
// - Take external interrupt when request asserted
// - Hold off when higher priority or disabled
// - Entry never clears the external request
// - Return address is next instruction address
// - Clear saved-state bits 33-36, 42-47
// - Copy bits 0,48-55,57-59,62-63 from state
// - Rewrite machine state for handler entry
// - Redirect fetch to external interrupt vector
// - Alignment saves state and reports cause
// - Float operand misaligned or crossing page
// - Multiple, reservation, control ops need alignment
// - Misaligned single access in little-endian
// - Multiple/string in slow memory or little-endian
// - Multiple crossing segment, block or attributes
// - Misaligned access to slow memory faults
// - Cache zero, reservation ops on slow memory
// - Failing conditional store fault is selectable
// - Fault status/address update may be skipped
// - Domains: segment, block, page, unmapped range
// - Domains exist only with translation on
// - Alignment return address is faulting instruction
module exception_entry #(
    parameter bit          UPDATE_FAULT_REGS = 1'b1,
    parameter bit          CSTORE_FAIL_ALIGN = 1'b1,
    parameter logic [63:0] ALIGN_VEC         = exc_pkg::ALIGN_VECTOR
) (
    input  wire logic               clk_i,
    input  wire logic               rstn_i,
    input  wire logic               ext_irq_i,
    input  wire logic               higher_prio_i,
    input  wire logic [63:0]        next_pc_i,
    input  wire logic               mem_valid_i,
    input  wire logic [63:0]        mem_pc_i,
    input  wire logic [63:0]        mem_ea_i,
    input  wire logic [7:0]         mem_size_i,
    input  wire exc_pkg::mem_kind_t mem_kind_i,
    input  wire logic               mem_wt_i,
    input  wire logic               mem_ci_i,
    input  wire logic               mem_seg_cross_i,
    input  wire logic               mem_attr_differ_i,
    input  wire logic               mem_cstore_fail_i,
    input  wire logic [7:0]         addr_i,
    input  wire logic [63:0]        wdata_i,
    input  wire logic               we_i,
    input  wire logic               re_i,
    output logic      [63:0]        rdata_o,
    output logic                    redirect_o,
    output logic      [63:0]        redirect_pc_o,
    output logic                    ext_taken_o,
    output logic                    align_taken_o,
    output logic      [63:0]        machine_state_o
);

    // ------------------------------------------------------------
    // Types and helpers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN      = 2'b00,
        ST_REDIRECT = 2'b01
    } entry_state_t;

    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off);
        wr_hit = a == off;
    endfunction : wr_hit

    entry_state_t               state_q;
    entry_state_t               state_d;
    logic [2:0]                 irq_sync_q;
    logic                       irq_lvl_q;
    logic [63:0]                era_q;
    logic [63:0]                esv_q;
    logic [63:0]                ms_q;
    logic [63:0]                fstat_q;
    logic [63:0]                faddr_q;
    logic [1:0]                 last_cause_q;
    logic [63:0]                rd_d;
    logic [63:0]                saved_w;
    logic [63:0]                ms_entry_w;
    logic                       align_hit;
    logic [exc_pkg::CAUSE_W-1:0] align_cause;
    logic                       run;
    logic                       align_take;
    logic                       ext_take;
    logic                       any_take;

    // ------------------------------------------------------------
    // Request synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            irq_sync_q <= 3'h0;
        end else begin
            irq_sync_q <= {irq_sync_q[1:0], ext_irq_i};
        end
    end

    // Level accepted only once two late stages agree
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            irq_lvl_q <= 1'b0;
        end else if (irq_sync_q[1] == irq_sync_q[2]) begin
            irq_lvl_q <= irq_sync_q[1];
        end
    end

    // ------------------------------------------------------------
    // Detection and arbitration
    // ------------------------------------------------------------
    align_checker #(
        .CSTORE_FAIL_ALIGN (CSTORE_FAIL_ALIGN)
    ) u_align (
        .ea_i          (mem_ea_i),
        .size_i        (mem_size_i),
        .kind_i        (mem_kind_i),
        .wt_i          (mem_wt_i),
        .ci_i          (mem_ci_i),
        .seg_cross_i   (mem_seg_cross_i),
        .attr_differ_i (mem_attr_differ_i),
        .cstore_fail_i (mem_cstore_fail_i),
        .dtrans_i      (ms_q[exc_pkg::MS_DTRANS]),
        .lendian_i     (ms_q[exc_pkg::MS_LENDIAN]),
        .hit_o         (align_hit),
        .cause_o       (align_cause)
    );

    entry_state_builder u_build (
        .ms_i    (ms_q),
        .saved_o (saved_w),
        .ms_o    (ms_entry_w)
    );

    // Synchronous alignment fault outranks the asynchronous request
    always_comb begin
        run        = state_q == ST_RUN;
        align_take = run && mem_valid_i && !higher_prio_i && align_hit;
        ext_take   = run && irq_lvl_q && ms_q[exc_pkg::MS_XIRQ_EN]
                     && !higher_prio_i && !align_take;
        any_take   = align_take || ext_take;
    end

    // ------------------------------------------------------------
    // Entry sequencer
    // ------------------------------------------------------------
    always_comb begin
        case (state_q)
            ST_RUN:      state_d = any_take ? ST_REDIRECT : ST_RUN;
            ST_REDIRECT: state_d = ST_RUN;
            default:     state_d = ST_RUN;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            redirect_o    <= 1'b0;
            redirect_pc_o <= exc_pkg::REG_RST;
            ext_taken_o   <= 1'b0;
            align_taken_o <= 1'b0;
        end else begin
            redirect_o    <= any_take;
            ext_taken_o   <= ext_take;
            align_taken_o <= align_take;
            if (align_take) begin
                redirect_pc_o <= ALIGN_VEC;
            end else if (ext_take) begin
                redirect_pc_o <= exc_pkg::EXT_VECTOR;
            end
        end
    end

    // ------------------------------------------------------------
    // Architected registers; entry wins over a software write
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            era_q <= exc_pkg::REG_RST;
        end else if (align_take) begin
            era_q <= mem_pc_i;
        end else if (ext_take) begin
            era_q <= next_pc_i;
        end else if (we_i && wr_hit(addr_i, exc_pkg::OFF_RET)) begin
            era_q <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            esv_q <= exc_pkg::REG_RST;
        end else if (any_take) begin
            esv_q <= saved_w;
        end else if (we_i && wr_hit(addr_i, exc_pkg::OFF_SAVED)) begin
            esv_q <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ms_q <= exc_pkg::REG_RST;
        end else if (any_take) begin
            ms_q <= ms_entry_w;
        end else if (we_i && wr_hit(addr_i, exc_pkg::OFF_MS)) begin
            ms_q <= wdata_i;
        end
    end

    // Skipping these updates leaves stale contents, which software must ignore
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            fstat_q <= exc_pkg::REG_RST;
            faddr_q <= exc_pkg::REG_RST;
        end else if (align_take && UPDATE_FAULT_REGS) begin
            fstat_q <= {{(64 - exc_pkg::CAUSE_W){1'b0}}, align_cause};
            faddr_q <= mem_ea_i;
        end else if (we_i && wr_hit(addr_i, exc_pkg::OFF_FSTAT)) begin
            fstat_q <= wdata_i;
        end else if (we_i && wr_hit(addr_i, exc_pkg::OFF_FADDR)) begin
            faddr_q <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            last_cause_q <= 2'h0;
        end else if (any_take) begin
            last_cause_q <= {align_take, ext_take};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            machine_state_o <= exc_pkg::REG_RST;
        end else begin
            machine_state_o <= any_take ? ms_entry_w : 
                               (we_i && wr_hit(addr_i, exc_pkg::OFF_MS)) ? wdata_i : ms_q;
        end
    end

    // ------------------------------------------------------------
    // Read port; request stays visible since entry never acknowledges it
    // ------------------------------------------------------------
    always_comb begin
        rd_d = 64'h0;
        case (addr_i)
            exc_pkg::OFF_RET:    rd_d = era_q;
            exc_pkg::OFF_SAVED:  rd_d = esv_q;
            exc_pkg::OFF_MS:     rd_d = ms_q;
            exc_pkg::OFF_FSTAT:  rd_d = fstat_q;
            exc_pkg::OFF_FADDR:  rd_d = faddr_q;
            exc_pkg::OFF_STATUS: rd_d = {60'h0, last_cause_q,
                                 irq_lvl_q && !ms_q[exc_pkg::MS_XIRQ_EN], irq_lvl_q};
            default:             rd_d = 64'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_o <= 64'h0;
        end else begin
            rdata_o <= re_i ? rd_d : 64'h0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence ext_entry_s;
        ext_taken_o ##0 redirect_o;
    endsequence

    sequence back_to_run_s;
        !redirect_o && state_q == ST_RUN;
    endsequence

    ext_recognise_a: assert property (
        (run && irq_lvl_q && ms_q[exc_pkg::MS_XIRQ_EN] && !higher_prio_i && !align_take)
        |=> ext_entry_s)
        else $error("enabled request not taken");

    ext_gate_a: assert property (
        ext_taken_o |-> $past(ms_q[exc_pkg::MS_XIRQ_EN]) && !$past(higher_prio_i))
        else $error("external entry while held off");

    req_kept_a: assert property (
        (ext_taken_o && irq_sync_q[1] && irq_sync_q[2] && $past(irq_lvl_q))
        |-> irq_lvl_q)
        else $error("request level dropped by entry");

    return_addr_a: assert property (
        ext_taken_o |-> era_q == $past(next_pc_i))
        else $error("wrong return address on external entry");

    saved_clear_a: assert property (
        ext_taken_o |-> (esv_q & exc_pkg::SAVED_CLEAR_MASK) == 64'h0)
        else $error("saved-state bits not cleared");

    saved_copy_a: assert property (
        ext_taken_o |-> (esv_q & exc_pkg::SAVED_COPY_MASK)
                        == ($past(ms_q) & exc_pkg::SAVED_COPY_MASK))
        else $error("saved-state copy wrong");

    state_rewrite_a: assert property (
        any_take |=> ms_q[exc_pkg::MS_WIDE] && !ms_q[exc_pkg::MS_XIRQ_EN]
                     && !ms_q[exc_pkg::MS_USER] && !ms_q[exc_pkg::MS_ITRANS]
                     && ms_q[exc_pkg::MS_LENDIAN] == ms_q[exc_pkg::MS_IENDIAN]
                     && ms_q[exc_pkg::MS_MCHK] == $past(ms_q[exc_pkg::MS_MCHK]))
        else $error("machine state not rewritten");

    ext_vector_a: assert property (
        ext_entry_s |-> redirect_pc_o == exc_pkg::EXT_VECTOR ##1 back_to_run_s)
        else $error("bad external redirect");

    align_entry_a: assert property (
        align_take |=> align_taken_o && redirect_pc_o == ALIGN_VEC
                       && era_q == $past(mem_pc_i))
        else $error("bad alignment entry");

    le_single_a: assert property (
        (run && mem_valid_i && !higher_prio_i && mem_kind_i == exc_pkg::KIND_INT
         && ms_q[exc_pkg::MS_LENDIAN] && mem_ea_i[0] && mem_size_i == 8'h2)
        |=> align_taken_o)
        else $error("little-endian misalign missed");

    slow_zero_a: assert property (
        (run && mem_valid_i && !higher_prio_i && mem_kind_i == exc_pkg::KIND_CZERO
         && (mem_wt_i || mem_ci_i)) |=> align_taken_o && fstat_q[6])
        else $error("cache zero fault missed");

    page_cross_a: assert property (
        (run && mem_valid_i && !higher_prio_i && mem_kind_i == exc_pkg::KIND_FLOAT
         && !ms_q[exc_pkg::MS_DTRANS] && mem_ea_i[1:0] == 2'h0 && !mem_wt_i && !mem_ci_i)
        |=> !align_taken_o)
        else $error("boundary fault with translation off");

endmodule : exception_entry

// [ext_irq_source.sv]
// Model of the outside interrupt source facing the exception-entry block.
// Assumes raise_i and clear_i are one-cycle pulses from the bench on clk_i.
module ext_irq_source (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic raise_i,
    input  wire logic clear_i,
    output logic      irq_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Request level
    // ------------------------------------------------------------
    // Entry never acknowledges, so only the handler's clear drops it
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            irq_o <= 1'b0;
        end else if (clear_i) begin
            irq_o <= 1'b0;
        end else if (raise_i) begin
            irq_o <= 1'b1;
        end
    end
endmodule : ext_irq_source

// [ext_irq_align_exception_entry_bench.sv]
// Self-checking bench for the exception-entry block.
// Assumes the block's default parameters and the source model beside it.
module ext_irq_align_exception_entry_bench;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int          LIMIT = 3000;
    localparam logic [63:0] COPY  = 64'h8000_0000_0000_ff73;
    logic clk_i = 1'b0, rstn_i = 1'b0, higher_prio_i = 1'b0, mem_valid_i = 1'b0;
    logic mem_wt_i = 1'b0, mem_ci_i = 1'b0, mem_seg_cross_i = 1'b0, we_i = 1'b0;
    logic mem_attr_differ_i = 1'b0, mem_cstore_fail_i = 1'b0, re_i = 1'b0;
    logic raise = 1'b0, clear = 1'b0, ext_irq_i, redirect_o, ext_taken_o, align_taken_o;
    logic [63:0] next_pc_i = 64'h1000, mem_pc_i = 64'h0, mem_ea_i = 64'h0, wdata_i = 64'h0;
    logic [63:0] rdata_o, redirect_pc_o, machine_state_o, v, n_ext = 64'h0;
    logic [7:0]  mem_size_i = 8'h04, addr_i = 8'h00;
    exc_pkg::mem_kind_t mem_kind_i = exc_pkg::KIND_INT;
    int          n_mismatch = 0, n_tests = 0, cyc = 0;

    always #12.5 clk_i = ~clk_i;

    ext_irq_source i_ext_irq_source (.clk_i, .rstn_i, .raise_i(raise), .clear_i(clear),
        .irq_o(ext_irq_i));
    exception_entry i_exception_entry (.clk_i, .rstn_i, .ext_irq_i, .higher_prio_i,
        .next_pc_i, .mem_valid_i, .mem_pc_i, .mem_ea_i, .mem_size_i, .mem_kind_i, .mem_wt_i,
        .mem_ci_i, .mem_seg_cross_i, .mem_attr_differ_i, .mem_cstore_fail_i, .addr_i,
        .wdata_i, .we_i, .re_i, .rdata_o, .redirect_o, .redirect_pc_o, .ext_taken_o,
        .align_taken_o, .machine_state_o);

    always @(posedge clk_i) begin
        if (ext_taken_o === 1'b1) n_ext++;
        cyc++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [63:0] d);
        @(posedge clk_i);
        we_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [63:0] d);
        @(posedge clk_i);
        re_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd

    task automatic pulse_src(input logic up);
        @(posedge clk_i);
        if (up) raise <= 1'b1;
        else clear <= 1'b1;
        @(posedge clk_i);
        raise <= 1'b0;
        clear <= 1'b0;
    endtask : pulse_src

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic reset_and_access();
        rd(exc_pkg::OFF_MS, v);
        chk("state after reset", 64'h0, v);
        rd(8'h30, v);
        chk("unmapped read", 64'h0, v);
        wr(exc_pkg::OFF_RET, 64'h0123_4567_89ab_cdef);
        rd(exc_pkg::OFF_RET, v);
        chk("return addr rw", 64'h0123_4567_89ab_cdef, v);
    endtask : reset_and_access

    task automatic ext_disabled();
        pulse_src(1'b1);
        repeat (6) @(posedge clk_i);
        chk("entries with enable off", 64'h0, n_ext);
        rd(exc_pkg::OFF_STATUS, v);
        chk("status pending", 64'h3, v);
    endtask : ext_disabled

    // All named fields set except width and data endian
    task automatic ext_entry();
        int i;
        @(posedge clk_i);
        higher_prio_i <= 1'b1;
        wr(exc_pkg::OFF_MS, 64'h0000_0000_0005_ff36);
        repeat (6) @(posedge clk_i);
        chk("entries under priority", 64'h0, n_ext);
        higher_prio_i <= 1'b0;
        next_pc_i     <= 64'h2468;
        for (i = 0; i < 10 && ext_taken_o !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk("ext taken", 64'h1, {63'h0, ext_taken_o});
        chk("redirect", 64'h1, {63'h0, redirect_o});
        chk("ext vector", 64'h500, redirect_pc_o);
        rd(exc_pkg::OFF_RET, v);
        chk("ext return addr", next_pc_i, v);
        rd(exc_pkg::OFF_SAVED, v);
        chk("ext saved state", 64'h0000_0000_0000_ff32, v);
        rd(exc_pkg::OFF_MS, v);
        chk("ext new state", 64'h8000_0000_0001_1001, v);
        chk("state port", 64'h8000_0000_0001_1001, machine_state_o);
        chk("single entry", 64'h1, n_ext);
        rd(exc_pkg::OFF_STATUS, v);
        chk("request kept", 64'h7, v);
        pulse_src(1'b0);
    endtask : ext_entry

    // Flags are {cstore fail, attr differ, segment cross, inhibited, write-through}
    task automatic align_case(input exc_pkg::mem_kind_t k, input logic [15:0] ea,
        input logic [7:0] sz, input logic [4:0] fl, input logic [1:0] md,
        input logic [6:0] cause);
        logic [63:0] ms;
        ms = {59'h0, md[1], 3'h0, md[0]};
        wr(exc_pkg::OFF_MS, ms);
        @(posedge clk_i);
        mem_valid_i <= 1'b1;
        mem_kind_i  <= k;
        mem_ea_i    <= {48'h0, ea};
        mem_pc_i    <= {48'h4, ea};
        mem_size_i  <= sz;
        {mem_cstore_fail_i, mem_attr_differ_i, mem_seg_cross_i, mem_ci_i, mem_wt_i} <= fl;
        @(posedge clk_i);
        mem_valid_i <= 1'b0;
        #1 chk("align taken", {63'h0, cause != 7'h0}, {63'h0, align_taken_o});
        if (cause != 7'h0) begin
            chk("align vector", 64'h600, redirect_pc_o);
            rd(exc_pkg::OFF_FSTAT, v);
            chk("fault status", {57'h0, cause}, v);
            rd(exc_pkg::OFF_FADDR, v);
            chk("fault address", {48'h0, ea}, v);
            rd(exc_pkg::OFF_RET, v);
            chk("align return addr", {48'h4, ea}, v);
            rd(exc_pkg::OFF_SAVED, v);
            chk("align saved state", ms & COPY, v);
        end
    endtask : align_case

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        reset_and_access();
        ext_disabled();
        ext_entry();
        align_case(exc_pkg::KIND_FLOAT, 16'h2, 8'h04, 5'h00, 2'h0, 7'h01);
        align_case(exc_pkg::KIND_FLOAT, 16'h0ffc, 8'h08, 5'h00, 2'h2, 7'h01);
        align_case(exc_pkg::KIND_FLOAT, 16'h0ffc, 8'h08, 5'h00, 2'h0, 7'h00);
        align_case(exc_pkg::KIND_MULTI, 16'h2, 8'h08, 5'h00, 2'h0, 7'h02);
        align_case(exc_pkg::KIND_EXTCTL, 16'h2, 8'h04, 5'h00, 2'h0, 7'h02);
        align_case(exc_pkg::KIND_RESERVE, 16'h4, 8'h08, 5'h00, 2'h0, 7'h02);
        align_case(exc_pkg::KIND_INT, 16'h1, 8'h02, 5'h00, 2'h1, 7'h04);
        align_case(exc_pkg::KIND_STRING, 16'h0, 8'h04, 5'h02, 2'h0, 7'h08);
        align_case(exc_pkg::KIND_MULTI, 16'h0, 8'h08, 5'h00, 2'h1, 7'h08);
        align_case(exc_pkg::KIND_MULTI, 16'h0, 8'h08, 5'h04, 2'h2, 7'h10);
        align_case(exc_pkg::KIND_MULTI, 16'h0, 8'h08, 5'h08, 2'h2, 7'h10);
        align_case(exc_pkg::KIND_MULTI, 16'h0, 8'h08, 5'h04, 2'h0, 7'h00);
        align_case(exc_pkg::KIND_INT, 16'h2, 8'h04, 5'h01, 2'h0, 7'h20);
        align_case(exc_pkg::KIND_CZERO, 16'h0, 8'h08, 5'h02, 2'h0, 7'h40);
        align_case(exc_pkg::KIND_RESERVE, 16'h0, 8'h04, 5'h01, 2'h0, 7'h40);
        align_case(exc_pkg::KIND_CSTORE, 16'h0, 8'h04, 5'h12, 2'h0, 7'h40);
        align_case(exc_pkg::KIND_INT, 16'h8, 8'h08, 5'h00, 2'h0, 7'h00);
        print_verdict();
    end
endmodule : ext_irq_align_exception_entry_bench
